/* src/irq_prioritizer.sv */
// Purpose: Two-level interrupt prioritizer and vector-call requester.
// Assumes: APB slave with 32-bit data; core reports returns and completed instructions.
// Notes: Only the eight low bits of each enable and priority register are implemented.
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/100ps

// Behaviour
// - Each source has its own software priority bit, low or high.
// - High level preempts a low routine; a high routine is never preempted.
// - All priority bits reset to low.
// - Simultaneous requests: high level serviced before low level.
// - Same level: smaller fixed order wins; reset above all.
// - External request zero: order 0, vector 0x0003, hardware cleared.
// - External request one: order 2, vector 0x0013, hardware cleared.
// - Serial receive and transmit share vector 0x0023 at order 4.
// - Timer-two high and low overflow share vector 0x002B at order 5.
// - Four serial-peripheral flags share vector 0x0033 at order 6.
// - Converter window 0x004B order 9, done 0x0053 order 10; 8 reserved.
// - Requests are sampled on every clock cycle with CE high and decoded every cycle.
// - At least 5 clocks: one detect cycle plus four call cycles.
// - After a return with a request pending, one instruction runs first.
// - Equal or higher running level holds new requests until return+one.
// - Levels come from base and extended priority register a; register b is unused.
module irq_prioritizer (
    // System.
    input wire logic CLOCK,
    input wire logic SRST,
    input wire logic CE,
    // APB slave.
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Event pulses from peripherals, by order.
    input wire logic [10:0] SRC_EVENT,
    // Core handshake.
    input wire logic GLOBAL_ENABLE,
    input wire logic RETURN_FROM_INTERRUPT_INSTR_DONE,
    input wire logic INSTR_DONE,
    output logic CALL_REQ,
    output logic [15:0] CALL_VECTOR,
    output logic CALL_ENTRY,
    output logic [1:0] ACTIVE_LEVELS
);
    logic [7:0] base_enable_reg;
    logic [7:0] ext_enable_reg_a;
    logic [7:0] base_priority_reg;
    logic [7:0] ext_priority_reg_a;
    logic [7:0] ext_priority_reg_b;
    logic [10:0] pending;
    logic [10:0] enable_vec;
    logic [10:0] level_vec;
    logic [10:0] eligible;
    logic [1:0] in_service;
    logic return_from_interrupt_instr_hold;
    logic [2:0] call_count;
    irq_prio_pkg::call_state_t state;
    irq_prio_pkg::vec_req_t winner;
    irq_prio_pkg::vec_req_t taken;
    logic wr_en;
    logic addr_ok;
    logic [10:0] sw_clear;
    logic start_call;

    // ************************************************************
    // APB access
    // ************************************************************
    assign PREADY = 1'b1;
    assign wr_en = PSEL & PENABLE & PWRITE & CE;
    always_comb begin
        addr_ok = 1'b1;
        unique case (PADDR)
            irq_prio_pkg::OFS_BASE_ENABLE,
            irq_prio_pkg::OFS_EXT_ENABLE_A,
            irq_prio_pkg::OFS_BASE_PRIORITY,
            irq_prio_pkg::OFS_EXT_PRIORITY_A,
            irq_prio_pkg::OFS_EXT_PRIORITY_B,
            irq_prio_pkg::OFS_STATUS,
            irq_prio_pkg::OFS_SW_FLAGS: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end
    assign PSLVERR = PSEL & PENABLE & ~addr_ok;

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            base_enable_reg <= irq_prio_pkg::RST_BYTE;
            ext_enable_reg_a <= irq_prio_pkg::RST_BYTE;
            base_priority_reg <= irq_prio_pkg::RST_BYTE;
            ext_priority_reg_a <= irq_prio_pkg::RST_BYTE;
            ext_priority_reg_b <= irq_prio_pkg::RST_BYTE;
        end else if (wr_en) begin
            if (PADDR == irq_prio_pkg::OFS_BASE_ENABLE)
                base_enable_reg <= PWDATA[7:0];
            if (PADDR == irq_prio_pkg::OFS_EXT_ENABLE_A)
                ext_enable_reg_a <= PWDATA[7:0];
            if (PADDR == irq_prio_pkg::OFS_BASE_PRIORITY)
                base_priority_reg <= PWDATA[7:0];
            if (PADDR == irq_prio_pkg::OFS_EXT_PRIORITY_A)
                ext_priority_reg_a <= PWDATA[7:0];
            if (PADDR == irq_prio_pkg::OFS_EXT_PRIORITY_B)
                ext_priority_reg_b <= PWDATA[7:0];
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            PRDATA <= 32'h0000_0000;
        end else if (CE && PSEL && !PENABLE && !PWRITE) begin
            PRDATA <= 32'h0000_0000;
            unique case (PADDR)
                irq_prio_pkg::OFS_BASE_ENABLE:
                    PRDATA[7:0] <= base_enable_reg;
                irq_prio_pkg::OFS_EXT_ENABLE_A:
                    PRDATA[7:0] <= ext_enable_reg_a;
                irq_prio_pkg::OFS_BASE_PRIORITY:
                    PRDATA[7:0] <= base_priority_reg;
                irq_prio_pkg::OFS_EXT_PRIORITY_A:
                    PRDATA[7:0] <= ext_priority_reg_a;
                irq_prio_pkg::OFS_EXT_PRIORITY_B:
                    PRDATA[7:0] <= ext_priority_reg_b;
                irq_prio_pkg::OFS_STATUS:
                    PRDATA[15:0] <= {3'h0, return_from_interrupt_instr_hold,
                                     state == irq_prio_pkg::ST_CALL,
                                     in_service, taken.order, taken.high,
                                     taken.valid, 3'h0};
                irq_prio_pkg::OFS_SW_FLAGS:
                    PRDATA[10:0] <= pending;
                default: PRDATA <= 32'h0000_0000;
            endcase
        end
    end

    // ************************************************************
    // Source mapping
    // ************************************************************
    // Orders 0..6 use the base registers; 7..10 the extended ones.
    // Extended register b is held for future sources beyond order 10.
    assign enable_vec = {ext_enable_reg_a[3:0], base_enable_reg[6:0]};
    assign level_vec = {ext_priority_reg_a[3:0],
                        base_priority_reg[6:0]};

    // Writing a one to a flag bit in the flag register clears it.
    assign sw_clear = (wr_en && PADDR == irq_prio_pkg::OFS_SW_FLAGS) ?
                      PWDATA[10:0] : 11'h000;

    genvar gi;
    generate
        for (gi = 0; gi < irq_prio_pkg::NSRC; gi++) begin : g_src
            logic hw_clr;
            assign hw_clr = start_call && winner.order == 4'(gi) &&
                            irq_prio_pkg::HW_CLEAR_MASK[gi];
            always_ff @(posedge CLOCK) begin
                if (SRST)
                    pending[gi] <= 1'b0;
                else if (CE) begin
                    // A new event wins over any clear in the same cycle.
                    if (SRC_EVENT[gi] && gi != 8)
                        pending[gi] <= 1'b1;
                    else if (hw_clr || sw_clear[gi])
                        pending[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // ************************************************************
    // Arbitration
    // ************************************************************
    // A request counts only above every level in service.
    always_comb begin
        for (int i = 0; i < irq_prio_pkg::NSRC; i++) begin
            eligible[i] = pending[i] & enable_vec[i] & GLOBAL_ENABLE &
                          ~in_service[1] &
                          (level_vec[i] | ~in_service[0]) &
                          (i != 8);
        end
    end

    always_comb begin
        winner = '0;
        // Scan from highest order down so the smallest order is last set.
        for (int i = irq_prio_pkg::NSRC - 1; i >= 0; i--) begin
            if (eligible[i] && level_vec[i]) begin
                winner.valid = 1'b1;
                winner.high = 1'b1;
                winner.order = 4'(i);
            end
        end
        if (!winner.valid) begin
            for (int i = irq_prio_pkg::NSRC - 1; i >= 0; i--) begin
                if (eligible[i]) begin
                    winner.valid = 1'b1;
                    winner.order = 4'(i);
                end
            end
        end
        winner.vector = irq_prio_pkg::VEC_BASE +
                        16'(winner.order) * irq_prio_pkg::VEC_STEP;
    end

    // ************************************************************
    // Call sequencing
    // ************************************************************
    // Detection happens in the cycle the winner is registered.
    // The return pulse itself blocks as well, so a request pending as the
    // return completes still waits for the following instruction.
    assign start_call = CE && state == irq_prio_pkg::ST_IDLE &&
                        winner.valid && !return_from_interrupt_instr_hold &&
                        !RETURN_FROM_INTERRUPT_INSTR_DONE;

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            state <= irq_prio_pkg::ST_IDLE;
            call_count <= 3'h0;
            taken <= '0;
        end else if (CE) begin
            unique case (state)
                irq_prio_pkg::ST_IDLE: begin
                    if (start_call) begin
                        taken <= winner;
                        state <= irq_prio_pkg::ST_CALL;
                        call_count <= 3'h0;
                    end
                end
                irq_prio_pkg::ST_CALL: begin
                    call_count <= call_count + 3'h1;
                    if (call_count == irq_prio_pkg::CALL_CYCLES - 3'h1) begin
                        state <= irq_prio_pkg::ST_IDLE;
                        taken.valid <= 1'b0;
                    end
                end
                default: state <= irq_prio_pkg::ST_IDLE;
            endcase
        end
    end

    assign CALL_REQ = state == irq_prio_pkg::ST_CALL;
    assign CALL_VECTOR = taken.vector;
    assign CALL_ENTRY = CALL_REQ &&
                        call_count == irq_prio_pkg::CALL_CYCLES - 3'h1;
    assign ACTIVE_LEVELS = in_service;

    // In-service levels are set at entry and unwound by return.
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            in_service <= 2'b00;
        end else if (CE) begin
            if (CALL_ENTRY)
                in_service[taken.high] <= 1'b1;
            else if (RETURN_FROM_INTERRUPT_INSTR_DONE) begin
                if (in_service[1])
                    in_service[1] <= 1'b0;
                else
                    in_service[0] <= 1'b0;
            end
        end
    end

    // After a return one more instruction must complete before a call.
    always_ff @(posedge CLOCK) begin
        if (SRST)
            return_from_interrupt_instr_hold <= 1'b0;
        else if (CE) begin
            if (RETURN_FROM_INTERRUPT_INSTR_DONE)
                return_from_interrupt_instr_hold <= 1'b1;
            else if (INSTR_DONE)
                return_from_interrupt_instr_hold <= 1'b0;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    AST_PRIO_RESET: assert property (@(posedge CLOCK)
        SRST |=> level_vec == 11'h000)
        else $error("priority bits not low after reset");

    AST_HIGH_NOT_PREEMPTED: assert property (@(posedge CLOCK)
        disable iff (SRST) in_service[1] |-> !start_call)
        else $error("call started during high routine");

    AST_HIGH_FIRST: assert property (@(posedge CLOCK)
        disable iff (SRST) (|(eligible & level_vec)) |-> winner.high)
        else $error("low request beat high request");

    AST_ORDER: assert property (@(posedge CLOCK)
        disable iff (SRST) start_call |->
        ((eligible & (winner.high ? level_vec : 11'h7FF) &
          ((11'h001 << winner.order) - 11'h001)) == 11'h000))
        else $error("smaller order request was skipped");

    AST_VEC0: assert property (@(posedge CLOCK)
        disable iff (SRST) winner.valid && winner.order == 4'h0 |->
        winner.vector == 16'h0003)
        else $error("order zero vector wrong");

    AST_VEC_SHARED: assert property (@(posedge CLOCK)
        disable iff (SRST) winner.valid && winner.order == 4'h4 |->
        winner.vector == 16'h0023)
        else $error("serial vector wrong");

    AST_ADC_VEC: assert property (@(posedge CLOCK)
        disable iff (SRST) winner.valid && winner.order == 4'hA |->
        winner.vector == 16'h0053 && !eligible[8])
        else $error("converter vector wrong");

    sequence s_start;
        start_call;
    endsequence
    AST_LATENCY: assert property (@(posedge CLOCK)
        disable iff (SRST || !CE) s_start |=> CALL_REQ [*4] ##1 !CALL_REQ)
        else $error("call length is not four cycles");

    AST_HOLD_AFTER_RETURN_FROM_INTERRUPT_INSTR: assert property (@(posedge CLOCK)
        disable iff (SRST) $rose(CALL_REQ) |->
        !$past(RETURN_FROM_INTERRUPT_INSTR_DONE) && !$past(return_from_interrupt_instr_hold))
        else $error("call before instruction after return");

    AST_HW_CLEAR: assert property (@(posedge CLOCK)
        disable iff (SRST) start_call && winner.order == 4'h0 &&
        !SRC_EVENT[0] |=> !pending[0])
        else $error("hardware flag not cleared at call");

    AST_SW_KEEP: assert property (@(posedge CLOCK)
        disable iff (SRST) start_call && winner.order == 4'h4 &&
        !sw_clear[4] |=> pending[4])
        else $error("software flag cleared by hardware");
endmodule

/* inc/irq_prio_pkg.sv */
// Purpose: Shared constants and carriers for the interrupt prioritizer.
// Assumes: Sources are numbered by their fixed arbitration order.
// Notes: Offsets are APB byte addresses.
package irq_prio_pkg;
    localparam int NSRC = 11;
    localparam logic [7:0] RST_BYTE = 8'h00;
    // Register byte offsets.
    localparam logic [7:0] OFS_BASE_ENABLE = 8'h00;
    localparam logic [7:0] OFS_EXT_ENABLE_A = 8'h04;
    localparam logic [7:0] OFS_BASE_PRIORITY = 8'h08;
    localparam logic [7:0] OFS_EXT_PRIORITY_A = 8'h0C;
    localparam logic [7:0] OFS_EXT_PRIORITY_B = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_SW_FLAGS = 8'h18;
    // Fixed vectors indexed by order.
    localparam logic [15:0] VEC_BASE = 16'h0003;
    localparam logic [15:0] VEC_STEP = 16'h0008;
    localparam logic [3:0] ORD_RESERVED = 4'h8;
    // Sources whose pending flag is cleared when the call is issued.
    localparam logic [10:0] HW_CLEAR_MASK = 11'h00F;
    // Long-call cycles after the detect cycle.
    localparam logic [2:0] CALL_CYCLES = 3'h4;
    typedef struct packed {
        logic valid;
        logic [3:0] order;
        logic [15:0] vector;
        logic high;
    } vec_req_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CALL = 2'b01
    } call_state_t;
endpackage

/* test/core_model.sv */
// Purpose: Behavioural processor core facing the prioritizer.
// Assumes: ISR_LEN sets routine length; one instruction takes 3 cycles.
// Notes: Nested routines share one timer, restarted on each entry.
`timescale 1ns/100ps
module core_model (
    // System.
    input wire logic CLOCK,
    input wire logic SRST,
    // Prioritizer side.
    input wire logic CALL_ENTRY,
    input wire logic [7:0] ISR_LEN,
    output logic RETURN_DONE,
    output logic INSTR_DONE
);
    int depth;
    int timer;
    int after;
    always_ff @(posedge CLOCK) begin
        RETURN_DONE <= 1'b0;
        INSTR_DONE <= 1'b0;
        if (SRST) begin
            depth <= 0;
            timer <= 0;
            after <= 0;
        end else if (CALL_ENTRY) begin
            depth <= depth + 1;
            timer <= int'(ISR_LEN);
        end else if (after > 0) begin
            after <= after - 1;
            if (after == 1) begin
                INSTR_DONE <= 1'b1;
                timer <= int'(ISR_LEN);
            end
        end else if (depth > 0 && timer == 0) begin
            RETURN_DONE <= 1'b1;
            depth <= depth - 1;
            after <= 3;
        end else if (depth > 0) begin
            timer <= timer - 1;
        end
    end
endmodule

/* test/two_level_interrupt_prioritizer_tb.sv */
// Purpose: Self-checking bench for the interrupt prioritizer.
// Assumes: Entry comes 6 edges after the edge that drives an event.
// Notes: The bench clears software flags inside each routine of the per-source test.
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin errors++; \
    $display("BAD %s exp %0h got %0h", nm, ex, gt); end end
module two_level_interrupt_prioritizer_tb;
    typedef struct {logic [15:0] vec; int t0; logic [1:0] lv;} note_t;
    logic CLOCK = 1'b0;
    logic SRST = 1'b1;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0;
    logic [31:0] PRDATA;
    logic PREADY, PSLVERR, RETURN_DONE, INSTR_DONE, CALL_REQ, CALL_ENTRY;
    logic GLOBAL_ENABLE = 1'b1;
    logic CE = 1'b1;
    logic hold = 1'b0;
    logic [10:0] SRC_EVENT = 11'h000;
    logic [15:0] CALL_VECTOR;
    logic [1:0] ACTIVE_LEVELS;
    logic [7:0] isr_len = 8'h18;
    int errors = 0;
    int checks = 0;
    int cyc = 0;
    int t_ev;
    note_t q[$];
    always #20 CLOCK = ~CLOCK;
    always @(posedge CLOCK) cyc <= cyc + 1;
    irq_prioritizer dut (.CLOCK(CLOCK), .SRST(SRST), .CE(CE),
        .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .SRC_EVENT(SRC_EVENT),
        .GLOBAL_ENABLE(GLOBAL_ENABLE), .RETURN_FROM_INTERRUPT_INSTR_DONE(RETURN_DONE),
        .INSTR_DONE(INSTR_DONE), .CALL_REQ(CALL_REQ),
        .CALL_VECTOR(CALL_VECTOR), .CALL_ENTRY(CALL_ENTRY),
        .ACTIVE_LEVELS(ACTIVE_LEVELS));
    core_model core (.CLOCK(CLOCK), .SRST(SRST), .CALL_ENTRY(CALL_ENTRY),
        .ISR_LEN(isr_len), .RETURN_DONE(RETURN_DONE),
        .INSTR_DONE(INSTR_DONE));
    // Watches every entry and pairs it with the oldest note.
    always @(posedge CLOCK) begin
        note_t n;
        if (RETURN_DONE === 1'b1) hold <= 1'b1;
        if (INSTR_DONE === 1'b1) hold <= 1'b0;
        if (hold === 1'b1) `CHK("held call", 1'b0, CALL_REQ)
        if (CALL_ENTRY === 1'b1) begin
            if (q.size() == 0) begin
                checks++;
                errors++;
                $display("BAD entry exp none got %0h", CALL_VECTOR);
            end else begin
                n = q.pop_front();
                `CHK("vector", n.vec, CALL_VECTOR)
                `CHK("levels", n.lv, ACTIVE_LEVELS)
                `CHK("call", 1'b1, CALL_REQ)
                if (n.t0 >= 0) `CHK("latency", n.t0 + 6, cyc)
            end
        end
    end
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic fail_wait();
        errors++;
        $display("BAD wait exp done got timeout");
        end_of_test();
    endtask
    task automatic apb(input logic [7:0] a, input logic w,
            input logic [31:0] d);
        int n;
        logic [31:0] v;
        logic e;
        n = 0;
        @(posedge CLOCK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLOCK);
        PENABLE <= 1'b1;
        do begin
            @(posedge CLOCK);
            n++;
        end while (PREADY !== 1'b1 && n < 16);
        if (n >= 16) fail_wait();
        v = PRDATA;
        e = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        `CHK("slave error", a > 8'h18, e)
        if (!w) `CHK("read data", d, v)
    endtask
    task automatic fire(input logic [10:0] m);
        @(posedge CLOCK);
        SRC_EVENT <= m;
        t_ev = cyc;
        @(posedge CLOCK);
        SRC_EVENT <= 11'h000;
    endtask
    task automatic expect_call(input logic [15:0] v, input int t0,
            input logic [1:0] lv);
        q.push_back('{v, t0, lv});
    endtask
    task automatic wait_entry();
        int n;
        n = 0;
        do begin
            @(posedge CLOCK);
            n++;
        end while (CALL_ENTRY !== 1'b1 && n < 60);
        if (n >= 60) fail_wait();
    endtask
    task automatic settle();
        int n;
        n = 0;
        while ((q.size() != 0 || ACTIVE_LEVELS !== 2'b00 || hold !== 1'b0
                || CALL_REQ !== 1'b0) && n < 600) begin
            @(posedge CLOCK);
            n++;
        end
        if (n >= 600) fail_wait();
        repeat (8) @(posedge CLOCK);
    endtask
    initial begin
        repeat (60000) @(posedge CLOCK);
        fail_wait();
    end
    initial begin
        logic [31:0] r;
        logic [7:0] regs [8];
        regs = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C};
        void'($urandom(73398));
        repeat (12) @(posedge CLOCK);
        SRST <= 1'b0;
        foreach (regs[i]) apb(regs[i], 1'b0, 32'h0);
        $display("test reset values done");
        r = $urandom();
        apb(irq_prio_pkg::OFS_BASE_PRIORITY, 1'b1,
            {24'h0, r[7:0]});
        apb(irq_prio_pkg::OFS_BASE_PRIORITY, 1'b0,
            {24'h0, r[7:0]});
        apb(irq_prio_pkg::OFS_EXT_PRIORITY_A, 1'b1, {24'h0, r[15:8]});
        apb(irq_prio_pkg::OFS_EXT_PRIORITY_A, 1'b0,
            {24'h0, r[15:8]});
        $display("test priority registers done");
        apb(irq_prio_pkg::OFS_BASE_ENABLE, 1'b1, 32'h7F);
        apb(irq_prio_pkg::OFS_EXT_ENABLE_A, 1'b1, 32'h0F);
        for (int o = 0; o < 11; o++) begin
            if (o == 8) continue;
            r = $urandom();
            apb(irq_prio_pkg::OFS_BASE_PRIORITY, 1'b1, {24'h0, r[7:0]});
            fire(11'h001 << o);
            expect_call(irq_prio_pkg::VEC_BASE + irq_prio_pkg::VEC_STEP
                * 16'(o), t_ev, 2'b00);
            wait_entry();
            r = (o < 4) ? 32'h0 : (32'h1 << o);
            apb(irq_prio_pkg::OFS_SW_FLAGS, 1'b0, r);
            apb(irq_prio_pkg::OFS_SW_FLAGS, 1'b1, 32'h1 << o);
            apb(irq_prio_pkg::OFS_SW_FLAGS, 1'b0, 32'h0);
            settle();
        end
        $display("test each source done");
        isr_len <= 8'h04;
        apb(irq_prio_pkg::OFS_BASE_PRIORITY, 1'b1, 32'h0);
        apb(irq_prio_pkg::OFS_EXT_PRIORITY_A, 1'b1, 32'h0);
        fire(11'h00A);
        expect_call(16'h000B, t_ev, 2'b00);
        expect_call(16'h001B, -1, 2'b00);
        settle();
        apb(irq_prio_pkg::OFS_BASE_PRIORITY, 1'b1, 32'h08);
        fire(11'h009);
        expect_call(16'h001B, t_ev, 2'b00);
        expect_call(16'h0003, -1, 2'b00);
        settle();
        $display("test arbitration done");
        isr_len <= 8'h28;
        apb(irq_prio_pkg::OFS_BASE_PRIORITY, 1'b1, 32'h03);
        fire(11'h004);
        expect_call(16'h0013, t_ev, 2'b00);
        wait_entry();
        fire(11'h001);
        expect_call(16'h0003, t_ev, 2'b01);
        wait_entry();
        fire(11'h002);
        expect_call(16'h000B, -1, 2'b01);
        settle();
        $display("test preemption done");
        isr_len <= 8'h04;
        apb(irq_prio_pkg::OFS_BASE_ENABLE, 1'b1, 32'h7E);
        fire(11'h101);
        repeat (12) @(posedge CLOCK);
        GLOBAL_ENABLE <= 1'b0;
        apb(irq_prio_pkg::OFS_BASE_ENABLE, 1'b1, 32'h7F);
        repeat (12) @(posedge CLOCK);
        expect_call(16'h0003, -1, 2'b00);
        GLOBAL_ENABLE <= 1'b1;
        settle();
        $display("test masking done");
        // An event pulse while the block is frozen must be lost; an entry
        // with no note queued is counted as a mismatch by the watcher.
        CE <= 1'b0;
        fire(11'h001);
        repeat (12) @(posedge CLOCK);
        CE <= 1'b1;
        settle();
        $display("test clock enable done");
        end_of_test();
    end
endmodule
